// [hbp_pkg.sv]
package hbp_pkg;
  // clock and watchdog timing
  localparam int CLK_MHZ = 125;
  localparam int WD_SHORT_MS = 25;
  localparam int WD_LONG_MS = 500;
  localparam int WD_SHORT_CYC = WD_SHORT_MS * CLK_MHZ * 1000;
  localparam int WD_LONG_CYC = WD_LONG_MS * CLK_MHZ * 1000;
  localparam int WD_CNT_W = 26;
  // gate timing steps, plain defaults
  localparam int PRC_STEP_NS = 250;
  localparam int BLANK_STEP_NS = 500;
  localparam int DLY_NS = 1000;
  localparam int TIMEOUT_NS = 8000;
  localparam int PRC_STEP_CYC = (PRC_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int BLANK_STEP_CYC = (BLANK_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int DLY_CYC = (DLY_NS * CLK_MHZ + 999) / 1000;
  localparam int TIMEOUT_CYC = (TIMEOUT_NS * CLK_MHZ) / 1000;
  localparam int TMR_W = 12;
  // command addresses, bits 15:12 of a frame
  localparam logic [3:0] CMD_SELECT = 4'h0;
  localparam logic [3:0] CMD_MODE = 4'h1;
  localparam logic [3:0] CMD_PWM = 4'h2;
  localparam logic [3:0] CMD_SOURCE = 4'h3;
  localparam logic [3:0] CMD_CFGA_LO = 4'h5;
  localparam logic [3:0] CMD_CFGA_HI = 4'h8;
  localparam logic [3:0] CMD_DEGLITCH = 4'hE;
  // frame field positions
  localparam int WD_BIT = 11;
  localparam int EXT_BIT = 10;
  localparam int PERSIST_BIT = 7;
  localparam int SELECT_LSB = 4;
  localparam int DRV_BIT = 10;
  localparam int PUMP_BIT = 9;
  localparam int WDCFG_BIT = 8;
  localparam int BLANK_LSB = 8;
  localparam int TPC_LSB = 0;
  // status addresses and bits
  localparam logic [2:0] ST_DEVICE = 3'h0;
  localparam logic [2:0] ST_GATES = 3'h1;
  localparam logic [2:0] ST_UNUSED_A = 3'h2;
  localparam logic [2:0] ST_VDS = 3'h3;
  localparam logic [2:0] ST_CAL = 3'h4;
  localparam logic [2:0] ST_OUTPUT = 3'h5;
  localparam logic [2:0] ST_UNUSED_B = 3'h6;
  localparam logic [2:0] ST_REVISION = 3'h7;
  localparam int NM_BIT = 12;
  localparam int RCF_BIT = 10;
  localparam int FSM_BIT = 9;
  localparam int SERIAL_ERROR_FLAG_BIT = 8;
  localparam int FAULT_LSB = 4;
  // reset values
  localparam logic [2:0] SELECT_RST = 3'h0;
  localparam logic [3:0] BRIDGE_RST = 4'h0;
  // high-side gate drive phases
  typedef enum logic [1:0] {HBP_OFF, HBP_PRECHARGE, HBP_SLEW, HBP_STEADY} hbp_phase_t;
endpackage : hbp_pkg

// [hbp_control_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module hbp_control_regs #(
  parameter int WD_SHORT_CYCLES = hbp_pkg::WD_SHORT_CYC,
  parameter int WD_LONG_CYCLES = hbp_pkg::WD_LONG_CYC,
  parameter logic [5:0] REVISION_CODE = 6'h00 // arbitrary value
)(
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic csb_n,
  input wire logic si,
  output var logic so,
  output var logic so_oe_n,
  input wire logic [1:0] pwm_input_n,
  input wire logic test_mode_in,
  input wire logic pump_low_in,
  input wire logic pump_fail_in,
  input wire logic undervoltage_in,
  input wire logic overvoltage_in,
  input wire logic [7:0] vds_fault_in,
  input wire logic [8:0] cal_result_in,
  input wire logic [3:0] bridge_node_level,
  output var logic [3:0] high_gate_out,
  output var logic [3:0] low_gate_out,
  output var logic [7:0] high_gate_phase,
  output var logic gate_drive_enable,
  output var logic pump_switch_on,
  output var logic normal_mode_flag
);
  localparam int SW = 28;

  if (WD_SHORT_CYCLES < 2 || WD_LONG_CYCLES >= (1 << hbp_pkg::WD_CNT_W)
      || WD_SHORT_CYCLES > WD_LONG_CYCLES)
  begin : g_bad_param
    $error("watchdog cycle counts out of range");
  end

  // deglitch length in cycles for one bridge
  function automatic logic [hbp_pkg::TMR_W-1:0] dgl_len(input logic type2,
      input logic [1:0] blank, input logic [1:0] tpc);
    int n;
    n = (int'(tpc) + 1) * hbp_pkg::PRC_STEP_CYC + hbp_pkg::DLY_CYC;
    if (!type2)
      n = n + (int'(blank) + 1) * hbp_pkg::BLANK_STEP_CYC;
    return n[hbp_pkg::TMR_W-1:0];
  endfunction : dgl_len

  logic link_rst;
  logic [15:0] resp_word;
  logic [3:0] rx_cnt;
  logic [15:0] rx_shift;
  logic [15:0] rx_word;
  logic rx_ok;
  logic rx_start;
  logic rx_fresh;
  logic [3:0] tx_idx;

  //////////////////////////////////////////////////////////////////////////////
  // link domain, runs only while sclk toggles inside a frame

  // reset of the link flops, a flop so it is glitch free
  always_ff @(posedge clk)
  begin
    if (!resetn)
      link_rst <= 1'b1;
    else
      link_rst <= 1'b0;
  end

  // bit counter restarts with every chip select; link_rst covers power-up,
  // when no chip select edge may have been seen yet
  always_ff @(negedge sclk or posedge csb_n or posedge link_rst)
  begin
    if (csb_n || link_rst)
    begin
      rx_cnt <= 4'h0;
      rx_fresh <= 1'b1;
    end
    else
    begin
      rx_cnt <= rx_cnt + 4'h1;
      rx_fresh <= 1'b0;
    end
  end

  // frame flags must survive chip select release, so not cleared by it
  always_ff @(negedge sclk or posedge link_rst)
  begin
    if (link_rst)
    begin
      rx_ok <= 1'b0;
      rx_start <= 1'b0;
    end
    else
    begin
      rx_ok <= (rx_cnt == 4'hF); // length must be a multiple of 16
      if (rx_fresh)
        rx_start <= !rx_start; // once per frame, so 32-bit frames still count
    end
  end

  // input shifter, msb first, sampled on falling edge
  always_ff @(negedge sclk)
  begin
    rx_shift <= {rx_shift[14:0], si};
    if (rx_cnt == 4'hF)
      rx_word <= {rx_shift[14:0], si};
  end

  // response out on rising edge; resp_word is frozen for the whole frame
  always_ff @(posedge sclk or posedge csb_n or posedge link_rst)
  begin
    if (csb_n || link_rst)
    begin
      tx_idx <= 4'h0;
      so <= 1'b0;
    end
    else
    begin
      so <= resp_word[4'hF - tx_idx];
      tx_idx <= tx_idx + 4'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // crossings into the clk domain

  logic [2:0] csb_sync;
  logic [1:0] start_sync;
  logic [1:0] ok_sync;
  logic start_seen;
  logic [SW-1:0] stat_s1;
  logic [SW-1:0] stat_s2;
  logic frame_end;
  logic frame_valid;

  // two-flop synchronisers; third csb stage only for edge detect
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      csb_sync <= 3'h7;
      start_sync <= 2'h0;
      ok_sync <= 2'h0;
      stat_s1 <= '0;
      stat_s2 <= '0;
    end
    else
    begin
      csb_sync <= {csb_sync[1:0], csb_n};
      start_sync <= {start_sync[0], rx_start};
      ok_sync <= {ok_sync[0], rx_ok};
      stat_s1 <= {pwm_input_n, test_mode_in, pump_low_in, pump_fail_in, undervoltage_in,
                  overvoltage_in, vds_fault_in, cal_result_in, bridge_node_level};
      stat_s2 <= stat_s1;
    end
  end

  // rx_word settled long before the synced csb edge, so it is read directly
  assign frame_end = csb_sync[1] && !csb_sync[2];

  //////////////////////////////////////////////////////////////////////////////
  // frame check and watchdog

  logic wd_expect;
  logic [hbp_pkg::WD_CNT_W-1:0] wd_cnt;
  logic wd_expired;
  logic serial_err;
  logic watchdog_timeout_select;

  assign frame_valid = frame_end && (start_sync[1] != start_seen) && ok_sync[1]
                       && (rx_word[hbp_pkg::WD_BIT] == wd_expect);
  assign serial_err = (frame_end && !frame_valid) || wd_expired;

  // watchdog bit must toggle with each accepted frame, first one is 0
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      start_seen <= 1'b0;
      wd_expect <= 1'b0;
    end
    else if (frame_end)
    begin
      start_seen <= start_sync[1];
      if (frame_valid)
        wd_expect <= !wd_expect;
    end
  end

  // timeout measured from the last accepted frame
  always_ff @(posedge clk)
  begin
    if (!resetn || frame_valid)
    begin
      wd_cnt <= '0;
      wd_expired <= 1'b0;
    end
    else if (int'(wd_cnt) >= (watchdog_timeout_select ? WD_LONG_CYCLES : WD_SHORT_CYCLES) - 1)
    begin
      wd_cnt <= '0;
      wd_expired <= 1'b1;
    end
    else
    begin
      wd_cnt <= wd_cnt + 1'b1;
      wd_expired <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control registers

  logic status_read_persist;
  logic [2:0] status_read_select;
  logic [3:0] bridge_output_enable;
  logic [3:0] bridge_side_select;
  logic [3:0] bridge_pwm_select;
  logic [3:0] bridge_pwm_source;
  logic [3:0] deglitch_type_select;
  logic [1:0] blank_sel [4];
  logic [1:0] tpc_sel [4];
  logic [3:0] cmd;

  assign cmd = rx_word[15:12];

  // writes only from accepted frames; others leave contents alone
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      bridge_output_enable <= hbp_pkg::BRIDGE_RST;
      gate_drive_enable <= 1'b0;
      pump_switch_on <= 1'b0;
      watchdog_timeout_select <= 1'b0;
      bridge_side_select <= hbp_pkg::BRIDGE_RST;
      bridge_pwm_select <= hbp_pkg::BRIDGE_RST;
      bridge_pwm_source <= hbp_pkg::BRIDGE_RST;
      deglitch_type_select <= hbp_pkg::BRIDGE_RST;
      for (int i = 0; i < 4; i++)
      begin
        blank_sel[i] <= 2'h0;
        tpc_sel[i] <= 2'h0;
      end
    end
    else if (frame_valid)
    begin
      case (cmd)
        hbp_pkg::CMD_SELECT:
          bridge_output_enable <= rx_word[3:0];
        hbp_pkg::CMD_MODE:
        begin
          gate_drive_enable <= rx_word[hbp_pkg::DRV_BIT];
          pump_switch_on <= rx_word[hbp_pkg::PUMP_BIT];
          watchdog_timeout_select <= rx_word[hbp_pkg::WDCFG_BIT];
          bridge_side_select <= rx_word[3:0];
        end
        hbp_pkg::CMD_PWM:
          bridge_pwm_select <= rx_word[3:0];
        hbp_pkg::CMD_SOURCE:
          if (!rx_word[hbp_pkg::EXT_BIT])
            bridge_pwm_source <= {rx_word[6], rx_word[4], rx_word[2], rx_word[0]};
        hbp_pkg::CMD_DEGLITCH:
          deglitch_type_select <= rx_word[3:0];
        default:
          if (!rx_word[hbp_pkg::EXT_BIT] && cmd >= hbp_pkg::CMD_CFGA_LO
              && cmd <= hbp_pkg::CMD_CFGA_HI)
          begin
            blank_sel[cmd[1:0] - 2'h1] <= rx_word[hbp_pkg::BLANK_LSB +: 2];
            tpc_sel[cmd[1:0] - 2'h1] <= rx_word[hbp_pkg::TPC_LSB +: 2];
          end
      endcase
    end
  end

  // status pointer; a new selection wins over the single-shot return
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      status_read_persist <= 1'b0;
      status_read_select <= hbp_pkg::SELECT_RST;
    end
    else if (frame_valid)
    begin
      if (cmd == hbp_pkg::CMD_SELECT)
      begin
        status_read_persist <= rx_word[hbp_pkg::PERSIST_BIT];
        status_read_select <= rx_word[hbp_pkg::SELECT_LSB +: 3];
      end
      else if (!status_read_persist)
        status_read_select <= hbp_pkg::ST_DEVICE;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // latched diagnosis

  logic [2:0] sent_addr;
  logic [4:0] fault_lat;
  logic [7:0] gate_lat;
  logic [7:0] vds_lat;
  logic [8:0] cal_lat;
  logic serial_error_flag;
  logic registers_cleared_flag;
  logic [4:0] fault_live;

  assign sent_addr = resp_word[15:13];
  assign fault_live = stat_s2[25:21];

  function automatic logic read_of(input logic [2:0] a, input logic fv,
      input logic [2:0] sa);
    return fv && (sa == a);
  endfunction : read_of

  // set wins over clear; a bit drops only once its cause has gone
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      fault_lat <= 5'h00;
      gate_lat <= 8'h00;
      vds_lat <= 8'h00;
      cal_lat <= 9'h000;
      serial_error_flag <= 1'b0;
    end
    else
    begin
      fault_lat <= fault_live | (fault_lat
                   & {5{!read_of(hbp_pkg::ST_DEVICE, frame_valid, sent_addr)}});
      serial_error_flag <= serial_err | (serial_error_flag
                   & !read_of(hbp_pkg::ST_DEVICE, frame_valid, sent_addr));
      gate_lat <= {high_gate_out, low_gate_out} | (gate_lat
                   & {8{!read_of(hbp_pkg::ST_GATES, frame_valid, sent_addr)}});
      vds_lat <= stat_s2[20:13] | (vds_lat
                   & {8{!read_of(hbp_pkg::ST_VDS, frame_valid, sent_addr)}});
      cal_lat <= stat_s2[12:4] | (cal_lat
                   & {9{!read_of(hbp_pkg::ST_CAL, frame_valid, sent_addr)}});
    end
  end

  // normal mode while no serial fault; cleared flag marks the entry
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      normal_mode_flag <= 1'b0;
      registers_cleared_flag <= 1'b0;
    end
    else
    begin
      normal_mode_flag <= !serial_error_flag;
      // only a read that showed the flag clears it; the word sent right after
      // reset was built before the flag was set
      registers_cleared_flag <= (!normal_mode_flag && !serial_error_flag)
                   | (registers_cleared_flag
                   & !(read_of(hbp_pkg::ST_DEVICE, frame_valid, sent_addr)
                   && resp_word[hbp_pkg::RCF_BIT]));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // response word, rebuilt once per frame so it never moves under sclk

  logic resp_pending;
  logic [11:0] resp_data;

  always_comb
  begin
    resp_data = 12'h000;
    case (status_read_select)
      hbp_pkg::ST_DEVICE:
        resp_data = {fault_lat[4], registers_cleared_flag, serial_error_flag,
                     serial_error_flag, fault_lat[3:0], 4'h0};
      hbp_pkg::ST_GATES: resp_data = {4'h0, gate_lat};
      hbp_pkg::ST_VDS: resp_data = {4'h0, vds_lat};
      hbp_pkg::ST_CAL: resp_data = {3'h0, cal_lat};
      hbp_pkg::ST_OUTPUT: resp_data = {8'h00, stat_s2[3:0]};
      hbp_pkg::ST_REVISION: resp_data = {6'h00, REVISION_CODE};
      default: resp_data = 12'h000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      resp_pending <= 1'b1;
      resp_word <= 16'h0000;
      so_oe_n <= 1'b1;
    end
    else
    begin
      resp_pending <= frame_end;
      so_oe_n <= csb_sync[1];
      if (resp_pending)
        resp_word <= {status_read_select, normal_mode_flag, resp_data};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // gate drive per bridge

  logic [3:0] pwm_level;
  logic [hbp_pkg::TMR_W-1:0] dgl_cnt [4];
  logic [hbp_pkg::TMR_W-1:0] ph_tmr [4];
  hbp_pkg::hbp_phase_t phase [4];
  logic [1:0] pwm_sync;

  assign pwm_sync = stat_s2[27:26];

  // pwm edges pass only after staying put for the deglitch time
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      pwm_level <= 4'h0;
      for (int i = 0; i < 4; i++)
        dgl_cnt[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (pwm_sync[bridge_pwm_source[i]] == pwm_level[i])
          dgl_cnt[i] <= '0;
        else if (dgl_cnt[i] >= dgl_len(deglitch_type_select[i], blank_sel[i],
                 tpc_sel[i]) - 1'b1)
        begin
          pwm_level[i] <= pwm_sync[bridge_pwm_source[i]];
          dgl_cnt[i] <= '0;
        end
        else
          dgl_cnt[i] <= dgl_cnt[i] + 1'b1;
      end
    end
  end

  // pwm low turns both drivers of a pwm-selected bridge off
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      high_gate_out <= 4'h0;
      low_gate_out <= 4'h0;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        high_gate_out[i] <= bridge_output_enable[i] && gate_drive_enable && normal_mode_flag
                            && (!bridge_pwm_select[i] || pwm_level[i])
                            && bridge_side_select[i];
        low_gate_out[i] <= bridge_output_enable[i] && gate_drive_enable && normal_mode_flag
                           && (!bridge_pwm_select[i] || pwm_level[i])
                           && !bridge_side_select[i];
      end
    end
  end

  // high gate current phases
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < 4; i++)
      begin
        phase[i] <= hbp_pkg::HBP_OFF;
        ph_tmr[i] <= '0;
      end
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        ph_tmr[i] <= ph_tmr[i] + 1'b1;
        case (phase[i])
          hbp_pkg::HBP_OFF:
          begin
            ph_tmr[i] <= '0;
            if (high_gate_out[i])
              phase[i] <= hbp_pkg::HBP_PRECHARGE;
          end
          hbp_pkg::HBP_PRECHARGE:
            if (!high_gate_out[i])
              phase[i] <= hbp_pkg::HBP_OFF;
            else if (int'(ph_tmr[i]) >= (int'(tpc_sel[i]) + 1) * hbp_pkg::PRC_STEP_CYC - 1)
              phase[i] <= hbp_pkg::HBP_SLEW;
          hbp_pkg::HBP_SLEW:
            if (!high_gate_out[i])
              phase[i] <= hbp_pkg::HBP_OFF;
            else if (int'(ph_tmr[i]) >= hbp_pkg::TIMEOUT_CYC - 1)
              phase[i] <= hbp_pkg::HBP_STEADY;
          hbp_pkg::HBP_STEADY:
            if (!high_gate_out[i])
              phase[i] <= hbp_pkg::HBP_OFF;
          default:
            phase[i] <= hbp_pkg::HBP_OFF;
        endcase
      end
    end
  end

  // phase codes to the pins
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < 4; i++)
      high_gate_phase[2*i +: 2] <= phase[i];
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_single_shot_ptr: assert property (
    frame_valid && !status_read_persist && cmd != 4'h0 |=> status_read_select == 3'h0)
    else $error("single-shot pointer not returned");
  a_persist_keep: assert property (
    frame_valid && status_read_persist && cmd != 4'h0 |=> $stable(status_read_select))
    else $error("persistent pointer moved");
  a_resp_layout: assert property (
    resp_pending |=> resp_word[15:13] == status_read_select
    && resp_word[12] == $past(normal_mode_flag))
    else $error("response header wrong");
  a_unused_zero: assert property (
    resp_pending && (status_read_select == 3'h2 || status_read_select == 3'h6)
    |=> resp_word[11:0] == 12'h000)
    else $error("unused status not zero");
  a_enable_off: assert property (
    !bridge_output_enable[0] |=> !high_gate_out[0] && !low_gate_out[0])
    else $error("disabled bridge driven");
  a_side_select: assert property (
    normal_mode_flag && gate_drive_enable && bridge_output_enable[0] && !bridge_pwm_select[0]
    |=> high_gate_out[0] == $past(bridge_side_select[0])
    && low_gate_out[0] == !$past(bridge_side_select[0]))
    else $error("side wrong");
  a_ctrl_hold: assert property (
    frame_end && !frame_valid |=> $stable(bridge_output_enable)
    && $stable(bridge_side_select) && $stable(bridge_pwm_select))
    else $error("bad frame wrote control");
  a_rcf_entry: assert property (
    $rose(normal_mode_flag) |-> registers_cleared_flag)
    else $error("cleared flag missing on entry");
  a_phase_start: assert property (
    $rose(high_gate_out[0]) |=> phase[0] == hbp_pkg::HBP_PRECHARGE
    ##1 phase[0] != hbp_pkg::HBP_STEADY)
    else $error("phase order wrong");

  c_valid_frame: cover property (frame_valid);
  c_serial_error: cover property (frame_end && !frame_valid);
  c_steady: cover property (phase[0] == hbp_pkg::HBP_STEADY);
  c_persist_read: cover property (frame_valid && status_read_persist);
endmodule : hbp_control_regs
`default_nettype wire

// [hbp_spi_host.sv]
`timescale 1ns/1ps
`default_nettype none
// spi host model; sclk only runs inside frames
module hbp_spi_host (
  output var logic sclk,
  output var logic csb_n,
  output var logic si,
  input wire logic so
);
  logic wd = 1'b0;
  // idle bus: clock low, not selected
  initial
  begin
    sclk = 1'b0;
    csb_n = 1'b1;
    si = 1'b0;
  end
  // one frame, mode 1; bad repeats the old watchdog bit on purpose
  task automatic xfer(input logic [15:0] cmd, input logic bad, output logic [15:0] rx);
    logic [15:0] tx;
    tx = cmd;
    tx[11] = wd ^ bad;
    csb_n = 1'b0;
    #40;
    for (int i = 15; i >= 0; i--)
    begin
      sclk = 1'b1;
      si = tx[i];
      #32;
      sclk = 1'b0;
      rx[i] = so;
      #32;
    end
    csb_n = 1'b1;
    si = ~si; // released line must not keep a usable value
    #120;
    if (!bad)
      wd = ~wd;
  endtask : xfer
endmodule : hbp_spi_host
`default_nettype wire

// [hbp_control_regs_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module hbp_control_regs_tb_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] pwm_n = 2'h0;
  logic [4:0] flt = 5'h00; // test, pump low, pump fail, uv, ov
  logic [7:0] vds = 8'h5A;
  logic [8:0] cal = 9'h000;
  logic [3:0] node = 4'hA;
  logic sclk, csb_n, si, so, oe, gde, psw, nm;
  logic [3:0] hg, lg;
  logic [7:0] ph;
  logic [15:0] rx;
  int n_errors = 0;
  int num_checks = 0;
  ////////////////////////////////
  always #4 clk = ~clk;
  // short watchdog periods keep the run brief
  hbp_control_regs #(.WD_SHORT_CYCLES(4000), .WD_LONG_CYCLES(8000), .REVISION_CODE(6'h2B))
    hbp_control_regs_i (.clk(clk), .resetn(resetn), .sclk(sclk), .csb_n(csb_n), .si(si),
    .so(so), .so_oe_n(oe), .pwm_input_n(pwm_n), .test_mode_in(flt[4]), .pump_low_in(flt[3]),
    .pump_fail_in(flt[2]), .undervoltage_in(flt[1]), .overvoltage_in(flt[0]),
    .vds_fault_in(vds), .cal_result_in(cal), .bridge_node_level(node), .high_gate_out(hg),
    .low_gate_out(lg), .high_gate_phase(ph), .gate_drive_enable(gde), .pump_switch_on(psw),
    .normal_mode_flag(nm));
  hbp_spi_host hbp_spi_host_i (.sclk(sclk), .csb_n(csb_n), .si(si), .so(so));
  ////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic fr(input logic [15:0] cmd);
    hbp_spi_host_i.xfer(cmd, 1'b0, rx);
  endtask : fr
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic complete_run();
    if (n_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  ////////////////////////////////
  // main sequence; answers arrive one frame behind
  initial
  begin
    cyc(20);
    resetn <= 1'b1;
    cyc(5);
    chk({15'h0, oe}, 16'h0001);
    fr(16'h1601);
    cyc(4);
    chk({14'h0, gde, psw}, 16'h0003);
    // output enable must be low while the frame runs
    fork
      fr(16'h0051);
      begin
        cyc(20);
        chk({15'h0, oe}, 16'h0000);
      end
    join
    chk(rx, 16'h1400);
    cyc(8);
    chk({8'h0, hg, lg}, 16'h0010);
    cyc(100);
    chk({14'h0, ph[1:0]}, 16'h0002);
    cyc(1100);
    chk({14'h0, ph[1:0]}, 16'h0003);
    flt <= 5'h02;
    cyc(10);
    flt <= 5'h00;
    fr(16'h2000);
    chk(rx, 16'hB00A);
    fr(16'h2000);
    chk(rx, 16'h1020);
    fr(16'h2000);
    chk(rx, 16'h1000);
    for (int i = 0; i < 9; i++)
    begin
      fr({8'h00, 1'b1, 3'(i), 4'h1});
      if (i > 0)
        chk({13'h0, rx[15:13]}, 16'(i - 1));
      case (i - 1)
        1: chk({4'h0, rx[11:0]}, 16'h0010);
        2, 6: chk({4'h0, rx[11:0]}, 16'h0000);
        3: chk({4'h0, rx[11:0]}, 16'h005A);
        5: chk({4'h0, rx[11:0]}, 16'h000A);
        7: chk({4'h0, rx[11:0]}, 16'h002B);
        default: ;
      endcase
    end
    fr(16'h00F1);
    fr(16'h2000);
    fr(16'h2000);
    chk({13'h0, rx[15:13]}, 16'h0007);
    // deglitch type goes in before pwm starts
    fr(16'hE000);
    fr(16'h3000);
    fr(16'h2001);
    cyc(10);
    chk({8'h0, hg, lg}, 16'h0000);
    pwm_n <= 2'h1;
    cyc(190);
    chk({8'h0, hg, lg}, 16'h0000);
    cyc(110);
    chk({8'h0, hg, lg}, 16'h0010);
    hbp_spi_host_i.xfer(16'h1000, 1'b1, rx);
    cyc(4);
    chk({14'h0, gde, nm}, 16'h0002);
    fr(16'h0001);
    fr(16'h2000);
    chk(rx, 16'h0300);
    cyc(4);
    chk({15'h0, nm}, 16'h0001);
    fr(16'h1701);
    cyc(6000);
    chk({15'h0, nm}, 16'h0001);
    // low side of bridge 0 now active, short watchdog again
    fr(16'h1600);
    cyc(8);
    chk({8'h0, hg, lg}, 16'h0001);
    cyc(4092);
    chk({15'h0, nm}, 16'h0000);
    complete_run();
  end
  // hang guard
  initial
  begin
    cyc(100000);
    n_errors++;
    complete_run();
  end
endmodule : hbp_control_regs_tb_top
`default_nettype wire
